// [logic/psave_gate.sv]
// Purpose: gates serial receive and transmit by power-save setting, flow control, rts and dtr
// Assumes: rts_n, dtr_n and the strobes are synchronous to aclk; low level means ON
// Notes: the wake interval is a parameter so simulation can shorten it
`timescale 1ns/1ps
module psave_gate #(
	parameter int WAKE_CYCLES = psave_pkg::WAKE_CYC,
	parameter int CYC_ON_CYCLES = psave_pkg::CYC_ON_CYC,
	parameter int CYC_OFF_CYCLES = psave_pkg::CYC_OFF_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic rx_char,
	input wire logic tx_pending,
	input wire logic busy_other,
	output logic cts_n,
	output logic rx_accept,
	output logic tx_allow,
	output logic port_enabled,
	output logic idle_mode
);
	import psave_pkg::*;

	logic [1:0] mode_raw;
	logic flow_on;
	ps_mode_t mode;
	logic [31:0] stat_word;
	logic wake_busy, wake_done, wake_start, wake_abort;
	logic cyc_busy, cyc_done, cyc_start;
	logic rts_on, dtr_on, rts_q, dtr_q, rts_rise, dtr_rise;
	logic en_q, en_d, cyc_on_q, cyc_on_d, drop_q, drop_d;
	logic cts_n_q, rx_q, tx_q, idle_q, badcfg;
	logic cts_n_d, rx_d, tx_d, idle_d;
	// cyclic on-window, reloaded at each period start and after a data wake
	localparam int WIN_W = $clog2(CYC_ON_CYCLES + 1);
	logic [WIN_W-1:0] win_q, win_d;

	// ----------------------------------------
	// registers and timers
	// ----------------------------------------
	axil_regs u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.stat_word(stat_word),
		.mode(mode_raw),
		.flow_on(flow_on)
	);

	wake_timer #(.COUNT(WAKE_CYCLES)) u_wake (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(wake_start),
		.abort(wake_abort),
		.busy(wake_busy),
		.done(wake_done)
	);

	wake_timer #(.COUNT(CYC_ON_CYCLES + CYC_OFF_CYCLES)) u_cyc (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(cyc_start),
		.abort(1'b0),
		.busy(cyc_busy),
		.done(cyc_done)
	);

	// ----------------------------------------
	// wake control
	// ----------------------------------------
	assign mode = ps_mode_t'(mode_raw);
	assign rts_on = !rts_n;
	assign dtr_on = !dtr_n;
	assign rts_rise = rts_on && !rts_q;
	assign dtr_rise = dtr_on && !dtr_q;
	assign badcfg = (mode == PS_RTS) && flow_on;

	// cyclic window re-armed at the end of each period
	assign cyc_start = (mode == PS_CYCLIC) && (!cyc_busy || cyc_done);

	always_comb begin
		wake_start = 1'b0;
		wake_abort = 1'b0;
		drop_d = 1'b0;
		cyc_on_d = cyc_on_q;
		en_d = en_q;
		win_d = win_q;
		// the window stays open for the on time so a terminal that saw cts can still deliver
		if (cyc_start || wake_done) begin
			cyc_on_d = 1'b1;
			win_d = WIN_W'(CYC_ON_CYCLES);
		end else if (win_q != '0) begin
			win_d = win_q - WIN_W'(1);
		end
		unique case (mode)
			PS_OFF: begin
				en_d = 1'b1;
				wake_abort = 1'b1;
			end
			PS_CYCLIC: begin
				if ((win_q == '0) && !cyc_start && !wake_done && !wake_busy && !rx_char && !tx_pending) begin
					cyc_on_d = 1'b0;
				end
				if (!flow_on && rx_char && !en_q && !wake_busy) begin
					wake_start = 1'b1;
					drop_d = 1'b1;
				end
				en_d = (cyc_on_d || wake_done || (en_q && (rx_char || tx_pending))) && !wake_start;
			end
			PS_RTS: begin
				if (badcfg) begin
					en_d = 1'b0;
					wake_abort = 1'b1;
				end else if (rts_rise) begin
					wake_start = 1'b1;
					en_d = 1'b0;
				end else if (!rts_on) begin
					wake_abort = 1'b1;
					en_d = 1'b0;
				end else if (wake_done) begin
					en_d = 1'b1;
				end
			end
			PS_DTR: begin
				if (dtr_rise) begin
					wake_start = 1'b1;
					en_d = 1'b0;
				end else if (!dtr_on) begin
					wake_abort = 1'b1;
					en_d = 1'b0;
				end else if (wake_done) begin
					en_d = 1'b1;
				end
			end
		endcase
		if (mode != PS_CYCLIC && mode != PS_OFF) begin
			drop_d = rx_char && !en_q;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb begin
		cts_n_d = !en_d;
		rx_d = en_d && !drop_d;
		// held while flow control is on and rts is off, free-running otherwise
		tx_d = flow_on ? rts_on : 1'b1;
		// idle only when saving is on and nothing needs the block
		idle_d = (mode != PS_OFF) && !en_d && !wake_busy && !wake_start && !tx_pending
			&& !busy_other && !rx_char;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rts_q <= 1'b0;
			dtr_q <= 1'b0;
			en_q <= 1'b1;
			cyc_on_q <= 1'b0;
			drop_q <= 1'b0;
			win_q <= '0;
			cts_n_q <= 1'b0;
			rx_q <= 1'b1;
			tx_q <= 1'b1;
			idle_q <= 1'b0;
		end else begin
			rts_q <= rts_on;
			dtr_q <= dtr_on;
			en_q <= en_d;
			cyc_on_q <= cyc_on_d;
			drop_q <= drop_d;
			win_q <= win_d;
			cts_n_q <= cts_n_d;
			rx_q <= rx_d;
			tx_q <= tx_d;
			idle_q <= idle_d;
		end
	end

	assign stat_word = {26'h0, drop_q, !tx_q, badcfg, wake_busy, idle_q, en_q};
	assign cts_n = cts_n_q;
	assign rx_accept = rx_q;
	assign tx_allow = tx_q;
	assign port_enabled = en_q;
	assign idle_mode = idle_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_rts_wake;
		(mode == PS_RTS) && !flow_on && rts_rise;
	endsequence

	// wake sequences start on an off-to-on edge of the governing line
	sequence s_dtr_wake;
		(mode == PS_DTR) && dtr_rise;
	endsequence

	a_off_never_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_OFF) [*2] |-> !idle_mode && !cts_n && rx_accept)
		else $error("setting zero lets port idle or close");
	a_cts_tracks_en: assert property (@(posedge aclk) disable iff (!aresetn)
		cts_n == !port_enabled)
		else $error("cts does not follow port enable");
	a_tx_held_rts: assert property (@(posedge aclk) disable iff (!aresetn)
		flow_on && rts_n |=> !tx_allow)
		else $error("transmit not held while rts off");
	a_tx_free_noflow: assert property (@(posedge aclk) disable iff (!aresetn)
		!flow_on |=> tx_allow)
		else $error("transmit blocked without flow control");
	a_dtr_off_drop: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_DTR) && dtr_n |=> !rx_accept && !port_enabled)
		else $error("data accepted with dtr off");
	a_rts_off_drop: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_RTS) && !flow_on && rts_n |=> !rx_accept)
		else $error("data accepted with rts off");
	a_rts_wake_time: assert property (@(posedge aclk) disable iff (!aresetn)
		s_rts_wake ##1 ((mode == PS_RTS) && !rts_n && !flow_on) [*2] |-> wake_busy)
		else $error("rts wake timer not running");
	a_badcfg_closed: assert property (@(posedge aclk) disable iff (!aresetn)
		badcfg |=> !port_enabled)
		else $error("port enabled in invalid configuration");
	a_first_char_drop: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_CYCLIC) && !flow_on && rx_char && !port_enabled && !wake_busy |=> !rx_accept)
		else $error("wake character was accepted");
	a_idle_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_pending || busy_other |=> !idle_mode)
		else $error("idle entered while activity pending");

	// ----------------------------------------
	// wake and window checks
	// ----------------------------------------
	a_cyc_wake_open: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_CYCLIC) && wake_done && !rx_char |=> port_enabled)
		else $error("port not opened after data wake");
	a_rts_wake_done: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_RTS) && !flow_on && !rts_n && !rts_rise && wake_done |=> port_enabled)
		else $error("port not opened after rts wake");
	a_dtr_wake_done: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_DTR) && !dtr_n && !dtr_rise && wake_done |=> port_enabled)
		else $error("port not opened after dtr wake");
	a_dtr_wake_time: assert property (@(posedge aclk) disable iff (!aresetn)
		s_dtr_wake ##1 ((mode == PS_DTR) && !dtr_n) [*2] |-> wake_busy)
		else $error("dtr wake timer not running");
	a_badcfg_no_wake: assert property (@(posedge aclk) disable iff (!aresetn)
		badcfg |=> !wake_busy)
		else $error("wake timer runs in invalid configuration");
	a_off_no_wake: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_OFF) |=> !wake_busy)
		else $error("wake timer runs with saving off");
	a_tx_free_rts: assert property (@(posedge aclk) disable iff (!aresetn)
		flow_on && !rts_n |=> tx_allow)
		else $error("transmit held while rts on");
	a_dtr_on_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_DTR) && !dtr_n && dtr_q && port_enabled |=> port_enabled)
		else $error("port closed while dtr on");
	a_rts_on_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_RTS) && !flow_on && !rts_n && rts_q && port_enabled |=> port_enabled && !idle_mode)
		else $error("port closed or idle while rts on");
	a_dtr_keep_rx: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_DTR) && !dtr_n && dtr_q && port_enabled |=> rx_accept)
		else $error("data dropped with dtr on");
	a_win_open: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_CYCLIC) && cyc_start && !rx_char |=> port_enabled)
		else $error("cyclic window did not open");
	a_dtr_off_abort: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == PS_DTR) && dtr_n |=> !wake_busy)
		else $error("wake timer runs with dtr off");
endmodule

// [logic/psave_pkg.sv]
// Purpose: constants for the serial port power-save gating block
// Assumes: 25 MHz aclk, AXI4-Lite register access
// Notes: timing counts derive from times and clock rate
//
// What this block does
// - a two-bit power-save setting selects off, cyclic, rts-governed or dtr-governed saving, and resets to off.
// - with saving on, the block idles when nothing needs it and pending network or interface activity blocks idle.
// - with saving off the block never idles, keeps receive enabled and holds cts on; transmit still follows rts when flow control is on.
// - setting two together with hardware flow control is an unsupported combination.
// - setting one without flow control drops the first character as a wake trigger and accepts data after about 20 ms.
// - with flow control on and rts off the device holds its outgoing data until rts is on again.
// - with flow control off the device sends regardless of rts and lost data is not retried.
// - with setting zero all incoming data is received in every flow and rts state.
// - with setting two and no flow control data is received while rts is on and dropped while it is off.
// - with setting three data is received while dtr is on and dropped while it is off.
// - with setting two an rts off-to-on edge wakes the port within about 20 ms and rts on blocks idle.
// - with setting three a dtr off-to-on edge wakes the port within about 20 ms and dtr off allows idle.
// - cts is driven low when the port is enabled and high when it is disabled.
package psave_pkg;
	typedef enum logic [1:0] {
		PS_OFF,
		PS_CYCLIC,
		PS_RTS,
		PS_DTR
	} ps_mode_t;
	localparam logic [1:0] PS_RESET = 2'h0;
	localparam int CLK_HZ = 25000000;
	localparam int WAKE_MS = 20;
	localparam int WAKE_CYC = (CLK_HZ / 1000) * WAKE_MS;
	localparam int CYC_ON_MS = 20;
	localparam int CYC_OFF_MS = 2500;
	localparam int CYC_ON_CYC = (CLK_HZ / 1000) * CYC_ON_MS;
	localparam int CYC_OFF_CYC = (CLK_HZ / 1000) * CYC_OFF_MS;
	// register byte addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] ADDR_CMD = 4'h8;
	// control field positions
	localparam int CTRL_MODE_LO = 0;
	localparam int CTRL_FLOW_BIT = 4;
	// command word codes
	localparam logic [7:0] CMD_FLOW_ON = 8'h03;
	localparam logic [7:0] CMD_FLOW_OFF = 8'h00;
	// status field positions
	localparam int ST_ENABLED = 0;
	localparam int ST_IDLE = 1;
	localparam int ST_WAKING = 2;
	localparam int ST_BADCFG = 3;
	localparam int ST_TXHELD = 4;
	localparam int ST_DROP = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [logic/wake_timer.sv]
// Purpose: down counter that signals completion of a wake interval
// Assumes: start pulse reloads, abort clears
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
module wake_timer #(
	parameter int COUNT = 500000
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic abort,
	output logic busy,
	output logic done
);
	localparam int W = $clog2(COUNT + 1);
	logic [W-1:0] cnt_q, cnt_d;
	logic done_q, done_d;

	always_comb begin
		cnt_d = cnt_q;
		done_d = 1'b0;
		if (abort) begin
			cnt_d = '0;
		end else if (start) begin
			cnt_d = W'(COUNT);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - W'(1);
			done_d = (cnt_q == W'(1));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	assign busy = (cnt_q != '0);
	assign done = done_q;
endmodule

// [logic/axil_regs.sv]
// Purpose: AXI4-Lite slave with control, status and command words
// Assumes: one write and one read at a time
// Notes: unmapped addresses answer SLVERR, reads return zero there
`timescale 1ns/1ps
module axil_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic [31:0] stat_word,
	output logic [1:0] mode,
	output logic flow_on
);
	import psave_pkg::*;
	logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [3:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0] ws_q, ws_d;
	logic [1:0] br_q, br_d, rr_q, rr_d, mode_q, mode_d;
	logic flow_q, flow_d;

	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		bv_d = bv_q;
		br_d = br_q;
		mode_d = mode_q;
		flow_d = flow_q;
		rv_d = rv_q;
		rd_d = rd_q;
		rr_d = rr_q;
		if (s_awvalid && !aw_q && !bv_q) begin
			aw_d = 1'b1;
			awa_d = s_awaddr;
		end
		if (s_wvalid && !w_q && !bv_q) begin
			w_d = 1'b1;
			wd_d = s_wdata;
			ws_d = s_wstrb;
		end
		if (aw_q && w_q) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bv_d = 1'b1;
			br_d = RESP_OKAY;
			unique case (awa_q)
				ADDR_CTRL: begin
					if (ws_q[0]) begin
						mode_d = wd_q[CTRL_MODE_LO +: 2];
						flow_d = wd_q[CTRL_FLOW_BIT];
					end
				end
				ADDR_CMD: begin
					if (ws_q[0] && wd_q[7:0] == CMD_FLOW_ON) begin
						flow_d = 1'b1;
					end else if (ws_q[0] && wd_q[7:0] == CMD_FLOW_OFF) begin
						flow_d = 1'b0;
					end else begin
						br_d = RESP_SLVERR;
					end
				end
				ADDR_STAT: br_d = RESP_OKAY;
				default: br_d = RESP_SLVERR;
			endcase
		end
		if (bv_q && s_bready) begin
			bv_d = 1'b0;
		end
		if (s_arvalid && !rv_q) begin
			rv_d = 1'b1;
			rr_d = RESP_OKAY;
			unique case (s_araddr)
				ADDR_CTRL: rd_d = {27'h0, flow_q, 2'h0, mode_q};
				ADDR_STAT: rd_d = stat_word;
				ADDR_CMD: rd_d = 32'h0;
				default: begin
					rd_d = 32'h0;
					rr_d = RESP_SLVERR;
				end
			endcase
		end else if (rv_q && s_rready) begin
			rv_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 4'h0;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			bv_q <= 1'b0;
			br_q <= 2'h0;
			mode_q <= PS_RESET;
			flow_q <= 1'b0;
			rv_q <= 1'b0;
			rd_q <= 32'h0;
			rr_q <= 2'h0;
		end else begin
			aw_q <= aw_d;
			w_q <= w_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			bv_q <= bv_d;
			br_q <= br_d;
			mode_q <= mode_d;
			flow_q <= flow_d;
			rv_q <= rv_d;
			rd_q <= rd_d;
			rr_q <= rr_d;
		end
	end

	assign s_awready = !aw_q && !bv_q;
	assign s_wready = !w_q && !bv_q;
	assign s_bvalid = bv_q;
	assign s_bresp = br_q;
	assign s_arready = !rv_q;
	assign s_rvalid = rv_q;
	assign s_rdata = rd_q;
	assign s_rresp = rr_q;
	assign mode = mode_q;
	assign flow_on = flow_q;
endmodule

// [test/dte_model.sv]
// Purpose: terminal-side model driving rts, dtr and single characters
// Assumes: low level on rts_n and dtr_n means ON
// Notes: a queued character waits for cts only while hold_cts is set; sent holds until the next send
`timescale 1ns/1ps
module dte_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cts_n,
	input wire logic rts_on,
	input wire logic dtr_on,
	input wire logic send,
	input wire logic hold_cts,
	output logic rts_n,
	output logic dtr_n,
	output logic rx_char,
	output logic sent
);
	logic pend_q;

	// ----------------------------------------
	// line levels and character launch
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rts_n <= 1'b1;
			// dtr is pulled up, so it reads off until driven
			dtr_n <= 1'b1;
			pend_q <= 1'b0;
			rx_char <= 1'b0;
			sent <= 1'b0;
		end else begin
			rts_n <= !rts_on;
			dtr_n <= !dtr_on;
			rx_char <= 1'b0;
			// sent stays high from a launch until the next send request
			if (send) begin
				pend_q <= 1'b1;
				sent <= 1'b0;
			end
			if ((send || pend_q) && (!hold_cts || !cts_n)) begin
				rx_char <= 1'b1;
				sent <= 1'b1;
				pend_q <= 1'b0;
			end
		end
	end
endmodule

// [test/uart_power_save_gating_tb.sv]
// Purpose: self-checking bench for the power-save gating block
// Assumes: shortened wake and cyclic counts
// Notes: bus answers are checked from a queue by a monitor process
`timescale 1ns/1ps
module uart_power_save_gating_tb;
	import psave_pkg::*;
	localparam int WK = 20;
	localparam int CON = 10;
	localparam int COF = 40;
	logic aclk = 1'b0;
	logic aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	logic [3:0] s_awaddr, s_wstrb, s_araddr;
	logic [31:0] s_wdata, s_rdata, r;
	logic [1:0] s_bresp, s_rresp;
	logic rts_n, dtr_n, rx_char, tx_pending, busy_other, cts_n, rx_accept, tx_allow, port_enabled, idle_mode;
	logic rts_on, dtr_on, send, hold_cts, sent;
	logic [34:0] exp_q[$];
	int error_cnt = 0;
	int check_count = 0;
	int f, i;

	always #20 aclk = ~aclk;

	psave_gate #(.WAKE_CYCLES(WK), .CYC_ON_CYCLES(CON), .CYC_OFF_CYCLES(COF)) dut (.aclk(aclk),
		.aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
		.s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.rts_n(rts_n), .dtr_n(dtr_n), .rx_char(rx_char), .tx_pending(tx_pending), .busy_other(busy_other),
		.cts_n(cts_n), .rx_accept(rx_accept), .tx_allow(tx_allow), .port_enabled(port_enabled),
		.idle_mode(idle_mode));

	dte_model dte (.aclk(aclk), .aresetn(aresetn), .cts_n(cts_n), .rts_on(rts_on), .dtr_on(dtr_on),
		.send(send), .hold_cts(hold_cts), .rts_n(rts_n), .dtr_n(dtr_n), .rx_char(rx_char), .sent(sent));

	// ----------------------------------------
	// comparisons and verdict
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic cmp_bus(input logic [34:0] got);
		logic [34:0] e;
		check_count++;
		e = 'x;
		if (exp_q.size() > 0) e = exp_q.pop_front();
		if (got !== e) begin
			error_cnt++;
			$display("[FAIL] %0t bus answer %h exp %h", $time, got, e);
		end
	endtask

	always @(posedge aclk) begin
		if (s_bvalid && s_bready) cmp_bus({1'b0, s_bresp, 32'h0});
		if (s_rvalid && s_rready) cmp_bus({1'b1, s_rresp, s_rdata});
	end

	// ----------------------------------------
	// stimulus helpers
	// ----------------------------------------
	task automatic settle();
		repeat (3) @(posedge aclk);
		#1;
	endtask

	task automatic wait_out(input int which, input logic v, input int n);
		logic s;
		for (int k = 0; k < n; k++) begin
			@(posedge aclk);
			#1;
			s = (which == 0) ? port_enabled : (which == 1) ? idle_mode : sent;
			if (s === v) begin
				check_count++;
				return;
			end
		end
		error_cnt++;
		$display("[FAIL] %0t wait ran out", $time);
		finish_test();
	endtask

	// one access; d is write data or expected read data
	task automatic axi(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_hit, w_hit, ar_hit, done;
		int n;
		exp_q.push_back({rd, er, rd ? d : 32'h0});
		@(posedge aclk);
		if (rd) begin
			s_araddr <= a;
			s_arvalid <= 1'b1;
			s_rready <= 1'b1;
		end else begin
			s_awaddr <= a;
			s_wdata <= d;
			s_awvalid <= 1'b1;
			s_wvalid <= 1'b1;
			s_bready <= 1'b1;
		end
		done = 1'b0;
		for (n = 0; n < 50 && !done; n++) begin
			@(negedge aclk);
			aw_hit = s_awvalid && s_awready;
			w_hit = s_wvalid && s_wready;
			ar_hit = s_arvalid && s_arready;
			done = rd ? s_rvalid : s_bvalid;
			@(posedge aclk);
			if (aw_hit) s_awvalid <= 1'b0;
			if (w_hit) s_wvalid <= 1'b0;
			if (ar_hit) s_arvalid <= 1'b0;
			if (done) begin
				s_bready <= 1'b0;
				s_rready <= 1'b0;
			end
		end
		if (!done) begin
			error_cnt++;
			$display("[FAIL] %0t bus answer missing", $time);
			finish_test();
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'hf81a0c01));
		{aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{s_awaddr, s_araddr, s_wdata} = '0;
		s_wstrb = 4'hf;
		{tx_pending, busy_other, rts_on, dtr_on, send, hold_cts} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		chk(cts_n, 1'b0, "cts after reset");
		chk(idle_mode, 1'b0, "idle after reset");
		axi(1'b1, ADDR_CTRL, 32'h0, RESP_OKAY);
		axi(1'b0, 4'hc, 32'h1, RESP_SLVERR);
		axi(1'b1, 4'hc, 32'h0, RESP_SLVERR);
		axi(1'b0, ADDR_CMD, 32'h55, RESP_SLVERR);
		for (f = 0; f < 2; f++) begin
			axi(1'b0, ADDR_CMD, {24'h0, f ? CMD_FLOW_ON : CMD_FLOW_OFF}, RESP_OKAY);
			for (i = 0; i < 6; i++) begin
				r = $urandom;
				@(posedge aclk);
				rts_on <= r[0];
				dtr_on <= r[1];
				busy_other <= r[2];
				tx_pending <= r[3];
				settle();
				chk(rx_accept, 1'b1, "setting 0 receive");
				chk(cts_n, 1'b0, "setting 0 cts");
				chk(idle_mode, 1'b0, "setting 0 idle");
				chk(tx_allow, f ? r[0] : 1'b1, "setting 0 send");
			end
		end
		axi(1'b0, ADDR_CTRL, 32'h12, RESP_OKAY);
		settle();
		chk(cts_n, 1'b1, "setting 2 with flow");
		axi(1'b0, ADDR_CTRL, 32'h02, RESP_OKAY);
		@(posedge aclk);
		rts_on <= 1'b0;
		busy_other <= 1'b0;
		tx_pending <= 1'b0;
		settle();
		chk(rx_accept, 1'b0, "rts off receive");
		chk(cts_n, 1'b1, "rts off cts");
		chk(tx_allow, 1'b1, "rts off send");
		wait_out(1, 1'b1, 10);
		axi(1'b1, ADDR_STAT, 32'h1 << ST_IDLE, RESP_OKAY);
		@(posedge aclk) busy_other <= 1'b1;
		settle();
		chk(idle_mode, 1'b0, "busy blocks idle");
		@(posedge aclk);
		busy_other <= 1'b0;
		rts_on <= 1'b1;
		repeat (5) @(posedge aclk);
		#1;
		chk(port_enabled, 1'b0, "rts wake early");
		wait_out(0, 1'b1, WK + 5);
		settle();
		chk(rx_accept, 1'b1, "rts on receive");
		chk(cts_n, 1'b0, "rts on cts");
		chk(idle_mode, 1'b0, "rts on idle");
		axi(1'b0, ADDR_CTRL, 32'h13, RESP_OKAY);
		axi(1'b1, ADDR_CTRL, 32'h13, RESP_OKAY);
		@(posedge aclk);
		dtr_on <= 1'b0;
		rts_on <= 1'b0;
		tx_pending <= 1'b1;
		settle();
		chk(rx_accept, 1'b0, "dtr off receive");
		chk(cts_n, 1'b1, "dtr off cts");
		chk(tx_allow, 1'b0, "send held");
		@(posedge aclk);
		rts_on <= 1'b1;
		dtr_on <= 1'b1;
		settle();
		chk(tx_allow, 1'b1, "send released");
		wait_out(0, 1'b1, WK + 5);
		settle();
		chk(rx_accept, 1'b1, "dtr on receive");
		axi(1'b0, ADDR_CMD, {24'h0, CMD_FLOW_OFF}, RESP_OKAY);
		@(posedge aclk) rts_on <= 1'b0;
		settle();
		chk(tx_allow, 1'b1, "flow off send");
		axi(1'b0, ADDR_CTRL, 32'h01, RESP_OKAY);
		@(posedge aclk) tx_pending <= 1'b0;
		wait_out(0, 1'b0, CON + COF + 10);
		@(posedge aclk) send <= 1'b1;
		@(posedge aclk) send <= 1'b0;
		settle();
		chk(rx_accept, 1'b0, "wake char dropped");
		wait_out(0, 1'b1, WK + 5);
		axi(1'b0, ADDR_CMD, {24'h0, CMD_FLOW_ON}, RESP_OKAY);
		@(posedge aclk) hold_cts <= 1'b1;
		wait_out(0, 1'b0, CON + COF + 10);
		@(posedge aclk) send <= 1'b1;
		@(posedge aclk) send <= 1'b0;
		wait_out(2, 1'b1, CON + COF + 10);
		chk(rx_accept, 1'b1, "held char accepted");
		@(posedge aclk) aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		chk(port_enabled, 1'b1, "second reset port");
		axi(1'b1, ADDR_CTRL, 32'h0, RESP_OKAY);
		finish_test();
	end
endmodule
